/* logic/dac_cfg_regs.svh */
// Register offsets, field positions, reset values and frame counts of the converter setup bank
`ifndef DAC_CFG_REGS_SVH
`define DAC_CFG_REGS_SVH

// ==========================================================
// Register offsets
`define OFS_SERIAL_AND_POWER_CONTROL 4'h0
`define OFS_INTERPOLATION_MODULATION_CONFIG 4'h1
`define OFS_INPUT_PORT_CONFIG 4'h2
`define OFS_UNUSED_SLOT 4'h3
`define OFS_I_FINE_GAIN 4'h4
`define OFS_I_COARSE_GAIN 4'h5
`define OFS_I_OFFSET_HIGH 4'h6
`define OFS_I_OFFSET_LOW_AND_DIRECTION 4'h7
`define OFS_Q_FINE_GAIN 4'h8
`define OFS_Q_COARSE_GAIN 4'h9
`define OFS_Q_OFFSET_HIGH 4'hA
`define OFS_Q_OFFSET_LOW_AND_DIRECTION 4'hB
`define OFS_RESERVED_SLOT_A 4'hC
`define OFS_RESERVED_SLOT_B 4'hD
`define OFS_RESERVED_SLOT_C 4'hE

// ==========================================================
// Field positions
`define BIT_LSB_FIRST 6
`define BIT_SOFT_RESET 5
`define BIT_INTERP_CLOCK_STOP 4
`define BIT_I_POWER_DOWN 3
`define BIT_Q_POWER_DOWN 2
`define BIT_THIRD_STAGE_HIGHPASS 5
`define BIT_REAL_MODE 2
`define BIT_SIGN_INVERT 1
`define BIT_OFFSET_BINARY 7
`define BIT_DUAL_PORT 6
`define BIT_ALT_WORD_CLOCK_PIN 5
`define BIT_FALLING_EDGE_LATCH 4
`define BIT_WORD_CLOCK_OUTPUT 3
`define BIT_SYNC_DISABLE 2
`define BIT_OFFSET_DIRECTION 7
`define BIT_CTRL_READ 7

// ==========================================================
// Writable bits per register (software reset bit is a strobe, not stored)
`define MASK_SERIAL_AND_POWER_CONTROL 8'h5C
`define MASK_INTERPOLATION_MODULATION_CONFIG 8'hFE
`define MASK_INPUT_PORT_CONFIG 8'hFC
`define MASK_FULL_BYTE 8'hFF
`define MASK_COARSE_GAIN 8'h0F
`define MASK_OFFSET_LOW 8'h83
`define MASK_NONE 8'h00

// ==========================================================
// Reset values
`define RST_INTERPOLATION_MODULATION_CONFIG 8'hD4
`define RST_COARSE_GAIN 8'h0F
`define RST_ZERO 8'h00

// ==========================================================
// Serial frame: control byte then data byte
`define FRAME_CTRL_LAST 5'h07
`define FRAME_DATA_FIRST 5'h08
`define FRAME_DATA_LAST 5'h0F
`define FRAME_BITS 5'h10

`endif

/* logic/dac_cfg_pkg.sv */
// Types shared by the converter setup bank
package dac_cfg_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] reg_addr_t;
	typedef logic [4:0] bit_count_t;
endpackage

/* logic/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic level_o
);
	logic stage1;
	logic stage2;
	logic stage3;

	// ==========================================================
	// Capture chain; stage1 feeds only stage2 to keep metastability contained
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			stage1 <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			stage3 <= RESET_LEVEL;
		end else begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Level moves only when the two settled stages agree
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			level_o <= RESET_LEVEL;
		end else if (stage2 == stage3) begin
			level_o <= stage3;
		end
	end
endmodule

`default_nettype wire

/* logic/dac_config_bank.sv */
// Serial-programmed configuration register bank of a dual interpolating converter
// What this block does
// RQ1: All operating modes come from registers written by the host over the serial port.
// RQ2: After reset every field holds its default value.
// RQ3: Writing 1 to bit 5 at 00h restores all defaults, itself included.
// RQ4: Bit 5 of 01h picks lowpass or highpass third filter stage.
// RQ5: Bit 2 of 02h at 0 enables the input synchroniser, 1 disables.
// RQ6: Registers 04h and 08h hold 8-bit fine gains, reset to zero.
// RQ7: Offsets are 10 bits: 06h/0Ah upper eight, 07h/0Bh bits 1:0 lower.
// RQ8: Bit 7 of 07h/0Bh steers offset to inverting (0) or noninverting (1).
// RQ9: Host never writes reserved addresses 0Ch, 0Dh, 0Eh.
// RQ10: Bit 6 of 00h selects MSB-first (0) or LSB-first (1) serial order.
// RQ11: Bit 4 of 00h stops the interpolator clock; outputs hold.
// RQ12: Bits 7:6 of 01h select 1x, 2x, 4x, 8x interpolation, default 8x.
// RQ13: Bits 4:3 of 01h select no, half or quarter rate modulation, default 10.
// RQ14: Bits 3 and 2 of 00h power down I and Q; both also downs interpolators.
// RQ15: Unused bits and register 03h accept writes with no effect.
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg_regs.svh"

module dac_config_bank (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic chip_select_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	output logic serial_data_o,
	output logic serial_data_oe_o,
	output logic lsb_first_o,
	output logic interp_clock_stop_o,
	output logic in_phase_converter_power_down_o,
	output logic quadrature_converter_power_down_o,
	output logic interp_power_down_o,
	output logic [1:0] interp_rate_o,
	output logic third_filter_stage_highpass_o,
	output logic [1:0] modulation_select_o,
	output logic real_modulation_o,
	output logic modulation_sign_invert_o,
	output logic offset_binary_o,
	output logic dual_port_o,
	output logic alt_word_clock_pin_o,
	output logic falling_edge_latch_o,
	output logic input_word_clock_output_o,
	output logic sync_disable_o,
	output logic [7:0] i_fine_gain_o,
	output logic [3:0] i_coarse_gain_o,
	output logic [9:0] i_offset_o,
	output logic i_offset_noninverting_o,
	output logic [7:0] q_fine_gain_o,
	output logic [3:0] q_coarse_gain_o,
	output logic [9:0] q_offset_o,
	output logic q_offset_noninverting_o
);
	// ==========================================================
	// Helper functions
	// Bits that software may change; reserved and unused slots are fixed at zero
	function automatic dac_cfg_pkg::byte_t write_mask(input dac_cfg_pkg::reg_addr_t addr);
		dac_cfg_pkg::byte_t m;
		m = `MASK_NONE;
		if (addr == `OFS_SERIAL_AND_POWER_CONTROL) begin
			m = `MASK_SERIAL_AND_POWER_CONTROL;
		end else if (addr == `OFS_INTERPOLATION_MODULATION_CONFIG) begin
			m = `MASK_INTERPOLATION_MODULATION_CONFIG;
		end else if (addr == `OFS_INPUT_PORT_CONFIG) begin
			m = `MASK_INPUT_PORT_CONFIG;
		end else if (addr == `OFS_I_FINE_GAIN || addr == `OFS_Q_FINE_GAIN ||
				addr == `OFS_I_OFFSET_HIGH || addr == `OFS_Q_OFFSET_HIGH) begin
			m = `MASK_FULL_BYTE; // see RQ6 see RQ7
		end else if (addr == `OFS_I_COARSE_GAIN || addr == `OFS_Q_COARSE_GAIN) begin
			m = `MASK_COARSE_GAIN;
		end else if (addr == `OFS_I_OFFSET_LOW_AND_DIRECTION ||
				addr == `OFS_Q_OFFSET_LOW_AND_DIRECTION) begin
			m = `MASK_OFFSET_LOW; // see RQ7 see RQ8
		end
		return m; // see RQ15
	endfunction

	// Default contents of each slot
	function automatic dac_cfg_pkg::byte_t reset_value(input dac_cfg_pkg::reg_addr_t addr);
		dac_cfg_pkg::byte_t v;
		v = `RST_ZERO;
		if (addr == `OFS_INTERPOLATION_MODULATION_CONFIG) begin
			v = `RST_INTERPOLATION_MODULATION_CONFIG; // see RQ12 see RQ13
		end else if (addr == `OFS_I_COARSE_GAIN || addr == `OFS_Q_COARSE_GAIN) begin
			v = `RST_COARSE_GAIN;
		end
		return v;
	endfunction

	// One serial bit into a byte, in the selected order
	function automatic dac_cfg_pkg::byte_t shift_in(input dac_cfg_pkg::byte_t cur,
			input logic bit_in, input logic lsb_first);
		return lsb_first ? {bit_in, cur[7:1]} : {cur[6:0], bit_in}; // see RQ10
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic cs_n_level;
	logic sclk_level;
	logic din_level;
	logic sclk_prev;
	logic sclk_rise;
	logic sclk_fall;

	pin_sync #(.RESET_LEVEL(1'b1)) cs_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(chip_select_n_i),
		.level_o(cs_n_level)
	);
	pin_sync #(.RESET_LEVEL(1'b0)) sclk_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(serial_clock_i),
		.level_o(sclk_level)
	);
	pin_sync #(.RESET_LEVEL(1'b0)) din_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(serial_data_i),
		.level_o(din_level)
	);

	// Edge detection on the filtered serial clock
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_level;
		end
	end
	assign sclk_rise = sclk_level & ~sclk_prev & ~cs_n_level;
	assign sclk_fall = ~sclk_level & sclk_prev & ~cs_n_level;

	// ==========================================================
	// Serial frame
	dac_cfg_pkg::byte_t cfg [16];
	dac_cfg_pkg::bit_count_t bit_count;
	dac_cfg_pkg::byte_t shift_reg;
	dac_cfg_pkg::byte_t ctrl_byte;
	dac_cfg_pkg::byte_t tx_byte;
	dac_cfg_pkg::byte_t next_shift;
	logic lsb_first;
	logic write_strobe;
	logic soft_reset;

	assign lsb_first = cfg[`OFS_SERIAL_AND_POWER_CONTROL][`BIT_LSB_FIRST];
	assign next_shift = shift_in(shift_reg, din_level, lsb_first);

	// Bit counter; extra clocks after the data byte are ignored until select rises
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || cs_n_level) begin
			bit_count <= '0;
		end else if (sclk_rise && bit_count != `FRAME_BITS) begin
			bit_count <= bit_count + 5'h01;
		end
	end

	// Receive shift register and control byte capture
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			shift_reg <= '0;
			ctrl_byte <= '0;
		end else if (sclk_rise && bit_count != `FRAME_BITS) begin
			shift_reg <= next_shift; // see RQ1
			if (bit_count == `FRAME_CTRL_LAST) begin
				ctrl_byte <= next_shift;
			end
		end
	end

	// Read data: loaded at the end of the control byte, advanced on falling edges
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			tx_byte <= '0;
		end else if (sclk_rise && bit_count == `FRAME_CTRL_LAST) begin
			tx_byte <= cfg[next_shift[3:0]];
		end else if (sclk_fall && bit_count >= `FRAME_DATA_FIRST + 5'h01 &&
				bit_count <= `FRAME_DATA_LAST) begin
			tx_byte <= lsb_first ? {1'b0, tx_byte[7:1]} : {tx_byte[6:0], 1'b0}; // see RQ10
		end
	end

	assign serial_data_o = lsb_first ? tx_byte[0] : tx_byte[7];
	assign serial_data_oe_o = ~cs_n_level & ctrl_byte[`BIT_CTRL_READ] &
		(bit_count >= `FRAME_DATA_FIRST);

	// Write takes effect at the 16th rising edge; nonzero spare control bits void it
	assign write_strobe = sclk_rise && bit_count == `FRAME_DATA_LAST &&
		!ctrl_byte[`BIT_CTRL_READ] && ctrl_byte[6:4] == 3'h0;
	assign soft_reset = write_strobe && ctrl_byte[3:0] == `OFS_SERIAL_AND_POWER_CONTROL &&
		next_shift[`BIT_SOFT_RESET]; // see RQ3

	// ==========================================================
	// Register storage; the reset strobe bit itself is never stored
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || soft_reset) begin
			for (int i = 0; i < 16; i++) begin
				cfg[i] <= reset_value(4'(i)); // see RQ2 see RQ3
			end
		end else if (write_strobe) begin
			cfg[ctrl_byte[3:0]] <= (cfg[ctrl_byte[3:0]] & ~write_mask(ctrl_byte[3:0])) |
				(next_shift & write_mask(ctrl_byte[3:0])); // see RQ9 see RQ15
		end
	end

	// ==========================================================
	// Field outputs, straight from the stored bytes
	assign lsb_first_o = lsb_first;
	assign interp_clock_stop_o = cfg[`OFS_SERIAL_AND_POWER_CONTROL][`BIT_INTERP_CLOCK_STOP]; // see RQ11
	assign in_phase_converter_power_down_o =
		cfg[`OFS_SERIAL_AND_POWER_CONTROL][`BIT_I_POWER_DOWN]; // see RQ14
	assign quadrature_converter_power_down_o =
		cfg[`OFS_SERIAL_AND_POWER_CONTROL][`BIT_Q_POWER_DOWN]; // see RQ14
	// Full power-down also idles the filters; the serial port stays alive
	assign interp_power_down_o = in_phase_converter_power_down_o &
		quadrature_converter_power_down_o; // see RQ14
	assign interp_rate_o = cfg[`OFS_INTERPOLATION_MODULATION_CONFIG][7:6]; // see RQ12
	assign third_filter_stage_highpass_o =
		cfg[`OFS_INTERPOLATION_MODULATION_CONFIG][`BIT_THIRD_STAGE_HIGHPASS]; // see RQ4
	assign modulation_select_o = cfg[`OFS_INTERPOLATION_MODULATION_CONFIG][4:3]; // see RQ13
	assign real_modulation_o = cfg[`OFS_INTERPOLATION_MODULATION_CONFIG][`BIT_REAL_MODE];
	assign modulation_sign_invert_o =
		cfg[`OFS_INTERPOLATION_MODULATION_CONFIG][`BIT_SIGN_INVERT];
	assign offset_binary_o = cfg[`OFS_INPUT_PORT_CONFIG][`BIT_OFFSET_BINARY];
	assign dual_port_o = cfg[`OFS_INPUT_PORT_CONFIG][`BIT_DUAL_PORT];
	assign alt_word_clock_pin_o = cfg[`OFS_INPUT_PORT_CONFIG][`BIT_ALT_WORD_CLOCK_PIN];
	assign falling_edge_latch_o = cfg[`OFS_INPUT_PORT_CONFIG][`BIT_FALLING_EDGE_LATCH];
	assign input_word_clock_output_o = cfg[`OFS_INPUT_PORT_CONFIG][`BIT_WORD_CLOCK_OUTPUT];
	assign sync_disable_o = cfg[`OFS_INPUT_PORT_CONFIG][`BIT_SYNC_DISABLE]; // see RQ5
	assign i_fine_gain_o = cfg[`OFS_I_FINE_GAIN]; // see RQ6
	assign i_coarse_gain_o = cfg[`OFS_I_COARSE_GAIN][3:0];
	assign i_offset_o = {cfg[`OFS_I_OFFSET_HIGH], cfg[`OFS_I_OFFSET_LOW_AND_DIRECTION][1:0]}; // see RQ7
	assign i_offset_noninverting_o =
		cfg[`OFS_I_OFFSET_LOW_AND_DIRECTION][`BIT_OFFSET_DIRECTION]; // see RQ8
	assign q_fine_gain_o = cfg[`OFS_Q_FINE_GAIN]; // see RQ6
	assign q_coarse_gain_o = cfg[`OFS_Q_COARSE_GAIN][3:0];
	assign q_offset_o = {cfg[`OFS_Q_OFFSET_HIGH], cfg[`OFS_Q_OFFSET_LOW_AND_DIRECTION][1:0]}; // see RQ7
	assign q_offset_noninverting_o =
		cfg[`OFS_Q_OFFSET_LOW_AND_DIRECTION][`BIT_OFFSET_DIRECTION]; // see RQ8
endmodule

`default_nettype wire

/* verif/spi_host_model.sv */
// Serial host model that frames control and data bytes for the setup bank
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	input wire logic clock_i,
	input wire logic miso_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic mosi_o
);
	// ==========================================================
	// Idle lines from time zero: deselected, clock parked low
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end

	// ==========================================================
	// One whole frame; 8-clock phases outlast the 3-flop pin filter of the bank
	// Host programs every mode this way and never writes 0Ch-0Eh
	task automatic frame(input dac_cfg_pkg::byte_t ctrl, input dac_cfg_pkg::byte_t data,
			input logic lsb, output dac_cfg_pkg::byte_t rdata);
		dac_cfg_pkg::byte_t cur;
		rdata = 8'h00;
		@(posedge clock_i);
		cs_n_o <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			cur = (i < 8) ? ctrl : data;
			sclk_o <= 1'b0;
			mosi_o <= lsb ? cur[i % 8] : cur[7 - (i % 8)];
			repeat (8) @(posedge clock_i);
			sclk_o <= 1'b1;
			repeat (8) @(posedge clock_i);
			if (i >= 8) begin
				rdata[lsb ? (i - 8) : (15 - i)] = miso_i;
			end
		end
		sclk_o <= 1'b0;
		repeat (8) @(posedge clock_i);
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o; // Released line must not keep its last value
		repeat (8) @(posedge clock_i);
	endtask
endmodule

`default_nettype wire

/* verif/dac_cfg_chk.sv */
// Concurrent checks on the setup bank's serial pins and configuration outputs
`timescale 1ns/1ps
`default_nettype none

module dac_cfg_chk (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic chip_select_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_o,
	input wire logic serial_data_oe_o,
	input wire logic in_phase_converter_power_down_o,
	input wire logic quadrature_converter_power_down_o,
	input wire logic interp_power_down_o,
	input wire logic [1:0] interp_rate_o,
	input wire logic third_filter_stage_highpass_o,
	input wire logic [1:0] modulation_select_o,
	input wire logic sync_disable_o,
	input wire logic [7:0] i_fine_gain_o,
	input wire logic [9:0] i_offset_o,
	input wire logic i_offset_noninverting_o,
	input wire logic [7:0] q_fine_gain_o,
	input wire logic [9:0] q_offset_o,
	input wire logic q_offset_noninverting_o
);
	// ==========================================================
	// Settings move only inside a frame; 8 deselected clocks outlast the pin filter
	gain_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		chip_select_n_i [*8] |-> $stable(i_fine_gain_o) && $stable(q_fine_gain_o))
		else $error("fine gain moved while deselected");
	offset_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		chip_select_n_i [*8] |-> $stable(i_offset_o) && $stable(q_offset_o))
		else $error("offset moved while deselected");
	dir_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		chip_select_n_i [*8] |-> $stable({i_offset_noninverting_o, q_offset_noninverting_o}))
		else $error("offset direction moved while deselected");
	mode_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		chip_select_n_i [*8] |-> $stable({interp_rate_o, modulation_select_o,
		third_filter_stage_highpass_o, sync_disable_o}))
		else $error("mode bits moved while deselected");

	// ==========================================================
	// Reset defaults, full power-down and serial output behaviour
	reset_default_a: assert property (@(posedge clock_i)
		!rst_n_i |=> interp_rate_o == 2'h3 && modulation_select_o == 2'h2
		&& i_fine_gain_o == 8'h00 && !sync_disable_o && !third_filter_stage_highpass_o)
		else $error("defaults missing after reset");
	full_down_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		interp_power_down_o == (in_phase_converter_power_down_o
		&& quadrature_converter_power_down_o))
		else $error("interpolator power-down not tied to both converters");
	oe_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		chip_select_n_i [*6] |-> !serial_data_oe_o)
		else $error("read data driven while deselected");
	dout_steady_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		serial_data_oe_o && $past(serial_data_oe_o) && serial_clock_i
		&& $past(serial_clock_i, 5) |-> $stable(serial_data_o))
		else $error("read bit moved during high clock phase");

	// Main scenarios reached
	cover property (@(posedge clock_i) $rose(serial_data_oe_o));
	cover property (@(posedge clock_i) $rose(interp_power_down_o));
	cover property (@(posedge clock_i) $changed(interp_rate_o));
endmodule

bind dac_config_bank dac_cfg_chk chk (.clock_i, .rst_n_i, .chip_select_n_i, .serial_clock_i,
	.serial_data_o, .serial_data_oe_o, .in_phase_converter_power_down_o,
	.quadrature_converter_power_down_o, .interp_power_down_o, .interp_rate_o,
	.third_filter_stage_highpass_o, .modulation_select_o, .sync_disable_o, .i_fine_gain_o,
	.i_offset_o, .i_offset_noninverting_o, .q_fine_gain_o, .q_offset_o, .q_offset_noninverting_o);

`default_nettype wire

/* verif/tb_dac_config_bank.sv */
// Self-checking bench for the converter setup register bank
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg_regs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_dac_config_bank;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic chip_select_n_i, serial_clock_i, serial_data_i, serial_data_o, serial_data_oe_o;
	logic lsb_first_o, interp_clock_stop_o, in_phase_converter_power_down_o;
	logic quadrature_converter_power_down_o, interp_power_down_o, third_filter_stage_highpass_o;
	logic real_modulation_o, modulation_sign_invert_o, offset_binary_o, dual_port_o;
	logic alt_word_clock_pin_o, falling_edge_latch_o, input_word_clock_output_o, sync_disable_o;
	logic i_offset_noninverting_o, q_offset_noninverting_o, lsb;
	logic [1:0] interp_rate_o, modulation_select_o;
	logic [3:0] i_coarse_gain_o, q_coarse_gain_o;
	logic [7:0] i_fine_gain_o, q_fine_gain_o;
	logic [9:0] i_offset_o, q_offset_o;
	int n_fail = 0;
	int n_checks = 0;
	dac_cfg_pkg::byte_t spare;

	// ==========================================================
	// Clock, design and host
	always #10 clock_i = ~clock_i;

	dac_config_bank dut (.clock_i, .rst_n_i, .chip_select_n_i, .serial_clock_i, .serial_data_i,
		.serial_data_o, .serial_data_oe_o, .lsb_first_o, .interp_clock_stop_o,
		.in_phase_converter_power_down_o, .quadrature_converter_power_down_o,
		.interp_power_down_o, .interp_rate_o, .third_filter_stage_highpass_o,
		.modulation_select_o, .real_modulation_o, .modulation_sign_invert_o, .offset_binary_o,
		.dual_port_o, .alt_word_clock_pin_o, .falling_edge_latch_o, .input_word_clock_output_o,
		.sync_disable_o, .i_fine_gain_o, .i_coarse_gain_o, .i_offset_o, .i_offset_noninverting_o,
		.q_fine_gain_o, .q_coarse_gain_o, .q_offset_o, .q_offset_noninverting_o);

	spi_host_model host (.clock_i, .miso_i(serial_data_o), .cs_n_o(chip_select_n_i),
		.sclk_o(serial_clock_i), .mosi_o(serial_data_i));

	// ==========================================================
	// Register access and expectations
	task automatic wr(input dac_cfg_pkg::reg_addr_t a, input dac_cfg_pkg::byte_t d);
		dac_cfg_pkg::byte_t r;
		host.frame({4'h0, a}, d, lsb, r);
	endtask
	task automatic rd(input dac_cfg_pkg::reg_addr_t a, input dac_cfg_pkg::byte_t e);
		dac_cfg_pkg::byte_t r;
		host.frame({4'h8, a}, 8'h00, lsb, r);
		`CHK(r, e);
	endtask
	function automatic dac_cfg_pkg::byte_t dflt(input dac_cfg_pkg::reg_addr_t a);
		case (a)
			4'h1: return 8'hD4;
			4'h5, 4'h9: return 8'h0F;
			default: return 8'h00;
		endcase
	endfunction
	// Readback after writing all ones; unused bits and 03h stay zero
	function automatic dac_cfg_pkg::byte_t ones(input dac_cfg_pkg::reg_addr_t a);
		case (a)
			4'h1: return 8'hFE;
			4'h2: return 8'hFC;
			4'h3: return 8'h00;
			4'h5, 4'h9: return 8'h0F;
			4'h7, 4'hB: return 8'h83;
			default: return 8'hFF;
		endcase
	endfunction
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog: about 60 frames of 273 clocks fit well inside this span
	initial begin
		repeat (100000) @(posedge clock_i);
		n_fail++;
		end_of_test();
	end

	// Main sequence
	initial begin
		lsb = 1'b0;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		for (int a = 0; a < 16; a++) rd(a[3:0], dflt(a[3:0]));
		`CHK(interp_rate_o, 2'h3);
		`CHK(modulation_select_o, 2'h2);
		for (int a = 1; a < 12; a++) wr(a[3:0], 8'hFF);
		for (int a = 1; a < 12; a++) rd(a[3:0], ones(a[3:0]));
		`CHK(sync_disable_o, 1'b1);
		`CHK({i_fine_gain_o, q_fine_gain_o}, 16'hFFFF);
		`CHK(i_offset_o, 10'h3FF);
		// Every remaining 01h and 02h mode pin except rate, modulation select and filter stage must follow its own stored bit
		`CHK({offset_binary_o, dual_port_o, alt_word_clock_pin_o, falling_edge_latch_o,
			input_word_clock_output_o, real_modulation_o, modulation_sign_invert_o}, 7'h7F);
		// Coarse gains reset to all ones, so a value below that proves the write lands
		wr(4'h5, 8'h3A);
		wr(4'h9, 8'h05);
		`CHK({i_coarse_gain_o, q_coarse_gain_o}, 8'hA5);
		rd(4'h5, 8'h0A);
		for (int c = 0; c < 4; c++) begin
			wr(4'h1, {c[1:0], c[0], c[1:0], 3'h0});
			`CHK(interp_rate_o, c[1:0]);
			`CHK(modulation_select_o, c[1:0]);
			`CHK(third_filter_stage_highpass_o, c[0]);
		end
		wr(4'h2, 8'h00);
		`CHK(sync_disable_o, 1'b0);
		wr(4'h0, 8'h1C);
		`CHK(interp_clock_stop_o, 1'b1);
		`CHK(interp_power_down_o, 1'b1);
		wr(4'h0, 8'h08);
		`CHK({in_phase_converter_power_down_o, quadrature_converter_power_down_o,
			interp_power_down_o}, 3'h4);
		wr(4'h6, 8'h81);
		wr(4'h7, 8'h02);
		`CHK({i_offset_noninverting_o, i_offset_o}, 11'h206);
		wr(4'hA, 8'h3C);
		wr(4'hB, 8'h81);
		`CHK({q_offset_noninverting_o, q_offset_o}, 11'h4F1);
		wr(4'h0, 8'h20);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'hD4);
		rd(4'h4, 8'h00);
		// Nonzero spare control bits must void the write
		host.frame(8'h14, 8'h5A, lsb, spare);
		rd(4'h4, 8'h00);
		wr(4'h0, 8'h40);
		lsb = 1'b1;
		`CHK(lsb_first_o, 1'b1);
		// Not a bit palindrome, so a swapped order shows up in the readback
		wr(4'h4, 8'hC4);
		rd(4'h4, 8'hC4);
		wr(4'h0, 8'h20);
		`CHK(lsb_first_o, 1'b0);
		lsb = 1'b0;
		rd(4'h0, 8'h00);
		end_of_test();
	end
endmodule

`default_nettype wire
